// File: src/fscs_sequencer.sv
// Design decisions made here: register access over APB and the register offsets.
`default_nettype none

// How it works
// - Program row takes keys B6/D9, row in bits 31:16, opcode 0006.
// - Erase all (key DD, opcode 000A) clears user rows and supervisory rows.
// - Erase all only from debug port, programming mode, chip open.
// - Protected to open change runs a full erase all first.
// - Checksum returns 24-bit byte sum in bits 23:0, success nibble on top.
// - Row 8000 sums the whole flash, else that single user row.
// - One protection bit per row; protection bytes are rows divided by eight.
// - Chip protection byte sits in last byte of macro 0 supervisory row.
// - Write protection: key E0, macro bits 31:24, code 01/02/04, opcode 000D.
// - Non-blocking write runs pre-program, erase, program in order.
// - Each non-blocking phase end raises the programming interrupt.
// - While non-blocking work is owed, only resume is carried out.
// - Non-blocking write row uses key DA, row bits 31:16, opcode 0007.
// - Non-blocking program row has one phase, one interrupt, one resume.
// - Every call ends by writing a status word into the argument register.
// - Non-blocking program row uses key DB, row bits 31:16, opcode 0008.
// - Keys not matching the opcode fail with F000000C.
module fscs_sequencer #(
  parameter int ROW_BITS = 6,
  parameter int ROW_BYTES = 128,
  parameter int MACRO_COUNT = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // SRAM parameter fetch
  output logic sramRdEn,
  output logic [31:0] sramAddr,
  input wire logic [31:0] sramRdata,
  input wire logic sramRvalid,
  // Page latch
  output logic [7:0] latchMacro,
  output logic [$clog2(ROW_BYTES/4)-1:0] latchIdx,
  input wire logic [31:0] latchRdata,
  output logic latchClear,
  // Programming controller interrupt
  output logic progIrq
);

  localparam int ROWS = 1 << ROW_BITS;
  localparam int ROW_WORDS = ROW_BYTES / 4;
  localparam int WB = $clog2(ROW_WORDS);
  localparam int REGION = (ROWS + 1) * ROW_WORDS;
  localparam int TOTAL = MACRO_COUNT * REGION;
  localparam int AW = $clog2(TOTAL);
  // Rows per protection word: eight bits a byte, four bytes a word
  localparam int PROT_WORDS = ROWS / 32;

  function automatic logic [AW-1:0] wordAddr(input int m, input int r, input int w);
    wordAddr = AW'(m * REGION + r * ROW_WORDS + w);
  endfunction : wordAddr

  function automatic logic [23:0] byteSum(input logic [31:0] w);
    byteSum = 24'(w[7:0]) + 24'(w[15:8]) + 24'(w[23:16]) + 24'(w[31:24]);
  endfunction : byteSum

  fscs_pkg::fscs_state_t stateQ, stateD;
  fscs_pkg::fscs_op_t opQ, opD;
  logic [AW-1:0] cntQ, cntD, lastQ, lastD, rowBaseQ, rowBaseD;
  logic [31:0] paramQ, paramD, resQ, resD, argQ, postVal;
  logic [15:0] opcodeQ;
  logic [1:0] ctrlQ, nbLeftQ, nbLeftD;
  logic [7:0] chipQ, chipD, newChipQ, newChipD, protMacroQ, protMacroD, latchMacroQ, latchMacroD;
  logic [23:0] sumQ, sumD;
  logic reqQ, nbRunQ, nbRunD, thenProtQ, thenProtD, rdPendQ, post;
  logic irqQ, irqD, clrQ, clrD, sramRdQ, sramRdD, preadyQ, pslverrQ;
  logic [31:0] sramAddrQ, prdataQ;
  logic [31:0] memRdata, memWdata, rdMux;
  logic [AW-1:0] memAddr;
  logic memWe;

  // Parameter word fields
  wire [7:0] first_call_key = paramQ[7:0];
  wire [7:0] second_call_key = paramQ[15:8];
  wire [15:0] rowId = paramQ[31:16];
  wire [7:0] protCode = paramQ[23:16];
  wire [7:0] macroSel = paramQ[31:24];
  wire [8:0] keyInfo = fscs_pkg::keyFor(opcodeQ);
  wire [15:0] rowMacro = rowId >> ROW_BITS;
  wire [15:0] rowIn = rowId & 16'(ROWS - 1);
  wire rowOk = 32'(rowId) < MACRO_COUNT * ROWS;
  wire [AW-1:0] rowBase = wordAddr(int'(rowMacro), int'(rowIn), 0);
  wire [AW-1:0] protWordAddr = wordAddr(int'(rowMacro), ROWS, int'(rowIn >> 5));
  wire [AW-1:0] chipAddr = wordAddr(0, ROWS, ROW_WORDS - 1);
  wire [AW-1:0] supBase = wordAddr(int'(macroSel), ROWS, 0);
  wire [AW-1:0] supBase0 = wordAddr(0, ROWS, 0);
  wire legalCode = protCode == fscs_pkg::PROT_OPEN || protCode == fscs_pkg::PROT_PROTECTED
    || protCode == fscs_pkg::PROT_KILL;
  wire eraseAllOk = ctrlQ[fscs_pkg::CTRL_DEBUG_PORT_BIT] && ctrlQ[fscs_pkg::CTRL_PROG_MODE_BIT]
    && chipQ == fscs_pkg::PROT_OPEN;
  wire walkEnd = cntQ == lastQ;

  // APB decode
  wire selReq = paddr == fscs_pkg::REQ_OFFSET;
  wire selArg = paddr == fscs_pkg::ARG_OFFSET;
  wire selCtrl = paddr == fscs_pkg::CTRL_OFFSET;
  wire selStat = paddr == fscs_pkg::STAT_OFFSET;
  wire mapped = selReq | selArg | selCtrl | selStat;
  wire apbAccess = psel & penable & ~preadyQ;
  wire apbWrite = psel & penable & preadyQ & pwrite;
  // Argument and request belong to the sequencer while a call runs
  wire swReqWr = apbWrite & selReq & ~reqQ;
  wire swArgWr = apbWrite & selArg & ~reqQ;

  assign rdMux = selReq ? {reqQ, 15'h0000, opcodeQ}
    : selArg ? argQ
    : selCtrl ? {30'h0000_0000, ctrlQ}
    : selStat ? {16'h0000, stateQ, 1'b0, nbRunQ, nbLeftQ, chipQ}
    : 32'h0000_0000;

  // Flash port
  assign memAddr = (stateQ == fscs_pkg::ST_WALK) ? cntQ
    : (stateQ == fscs_pkg::ST_PCHK) ? protWordAddr : chipAddr;
  assign memWe = (stateQ == fscs_pkg::ST_WALK && opQ != fscs_pkg::OP_CSUM)
    || stateQ == fscs_pkg::ST_CHIPWR;
  assign memWdata = (stateQ == fscs_pkg::ST_CHIPWR) ? {newChipQ, 24'h00_0000}
    : (opQ == fscs_pkg::OP_PREPROG) ? 32'hFFFF_FFFF
    : (opQ == fscs_pkg::OP_PROG || opQ == fscs_pkg::OP_PROT) ? latchRdata
    : 32'h0000_0000;
  assign sumD = rdPendQ ? sumQ + byteSum(memRdata) : sumQ;

  fscs_flash_mem #(
    .DW(32),
    .DEPTH(TOTAL),
    .AW(AW)
  ) u_flash (
    .ref_clk(ref_clk),
    .we(memWe),
    .addr(memAddr),
    .wdata(memWdata),
    .rdata(memRdata)
  );

  always_comb
  begin
    stateD = stateQ;
    opD = opQ;
    cntD = cntQ + 1'b1;
    lastD = lastQ;
    rowBaseD = rowBaseQ;
    paramD = paramQ;
    resD = resQ;
    nbLeftD = nbLeftQ;
    nbRunD = nbRunQ;
    thenProtD = thenProtQ;
    newChipD = newChipQ;
    protMacroD = protMacroQ;
    latchMacroD = latchMacroQ;
    chipD = chipQ;
    irqD = 1'b0;
    clrD = 1'b0;
    sramRdD = 1'b0;
    post = 1'b0;
    postVal = resQ;
    case (stateQ)
      fscs_pkg::ST_BOOT:
        stateD = fscs_pkg::ST_BOOTRD;
      fscs_pkg::ST_BOOTRD:
      begin
        // Anything but a locked code counts as open
        if (memRdata[31:24] == fscs_pkg::PROT_PROTECTED || memRdata[31:24] == fscs_pkg::PROT_KILL)
        begin
          chipD = memRdata[31:24];
        end
        stateD = fscs_pkg::ST_IDLE;
      end
      fscs_pkg::ST_IDLE:
      begin
        if (reqQ && (opcodeQ == fscs_pkg::OPC_CHECKSUM || opcodeQ == fscs_pkg::OPC_WRITE_PROT))
        begin
          paramD = argQ;
          stateD = fscs_pkg::ST_DECODE;
        end
        else if (reqQ)
        begin
          sramRdD = 1'b1;
          stateD = fscs_pkg::ST_FETCH;
        end
      end
      fscs_pkg::ST_FETCH:
      begin
        if (sramRvalid)
        begin
          paramD = sramRdata;
          stateD = fscs_pkg::ST_DECODE;
        end
      end
      fscs_pkg::ST_DECODE:
      begin
        resD = fscs_pkg::STAT_OK;
        stateD = fscs_pkg::ST_FINISH;
        if (!keyInfo[8])
        begin
          resD = fscs_pkg::FAIL_OPCODE;
        end
        else if (first_call_key != fscs_pkg::FIRST_CALL_KEY || second_call_key != keyInfo[7:0])
        begin
          resD = fscs_pkg::FAIL_KEY;
        end
        else if (nbLeftQ != 2'h0 && opcodeQ != fscs_pkg::OPC_RESUME)
        begin
          resD = fscs_pkg::FAIL_PENDING;
        end
        else
        begin
          case (opcodeQ)
            fscs_pkg::OPC_PROGRAM_ROW, fscs_pkg::OPC_NB_WRITE_ROW, fscs_pkg::OPC_NB_PROGRAM_ROW:
            begin
              if (rowOk)
              begin
                stateD = fscs_pkg::ST_PCHK;
              end
              else
              begin
                resD = fscs_pkg::FAIL_ADDRESS;
              end
            end
            fscs_pkg::OPC_ERASE_ALL:
            begin
              if (eraseAllOk)
              begin
                opD = fscs_pkg::OP_ERASEALL;
                cntD = '0;
                lastD = AW'(TOTAL - 1);
                newChipD = chipQ;
                stateD = fscs_pkg::ST_WALK;
              end
              else
              begin
                resD = fscs_pkg::FAIL_PROT_MODE;
              end
            end
            fscs_pkg::OPC_CHECKSUM:
            begin
              opD = fscs_pkg::OP_CSUM;
              stateD = fscs_pkg::ST_WALK;
              if (rowId == fscs_pkg::CHECKSUM_ALL_ROWS)
              begin
                cntD = '0;
                lastD = AW'(TOTAL - 1);
              end
              else if (rowOk)
              begin
                cntD = rowBase;
                lastD = rowBase + AW'(ROW_WORDS - 1);
              end
              else
              begin
                resD = fscs_pkg::FAIL_ADDRESS;
                stateD = fscs_pkg::ST_FINISH;
              end
            end
            fscs_pkg::OPC_WRITE_PROT:
            begin
              if (32'(macroSel) >= MACRO_COUNT)
              begin
                resD = fscs_pkg::FAIL_ADDRESS;
              end
              else if (chipQ == fscs_pkg::PROT_KILL || (macroSel == 8'h00 && !legalCode))
              begin
                resD = fscs_pkg::FAIL_PROT_MODE;
              end
              else
              begin
                protMacroD = macroSel;
                latchMacroD = macroSel;
                newChipD = protCode;
                stateD = fscs_pkg::ST_WALK;
                if (macroSel == 8'h00 && chipQ == fscs_pkg::PROT_PROTECTED
                  && protCode == fscs_pkg::PROT_OPEN)
                begin
                  thenProtD = 1'b1;
                  opD = fscs_pkg::OP_ERASEALL;
                  cntD = '0;
                  lastD = AW'(TOTAL - 1);
                end
                else
                begin
                  opD = fscs_pkg::OP_PROT;
                  cntD = supBase;
                  lastD = supBase + AW'(PROT_WORDS - 1);
                end
              end
            end
            default:
            begin
              if (nbLeftQ == 2'h0)
              begin
                resD = fscs_pkg::FAIL_RESUMED;
              end
              else if (nbLeftQ == 2'h1)
              begin
                nbLeftD = 2'h0;
              end
              else
              begin
                // Resume starts the next phase and answers at once
                nbLeftD = nbLeftQ - 2'h1;
                opD = (nbLeftQ == 2'h3) ? fscs_pkg::OP_ERASE : fscs_pkg::OP_PROG;
                cntD = rowBaseQ;
                nbRunD = 1'b1;
                post = 1'b1;
                postVal = fscs_pkg::STAT_OK;
                stateD = fscs_pkg::ST_WALK;
              end
            end
          endcase
        end
      end
      fscs_pkg::ST_PCHK:
        stateD = fscs_pkg::ST_PCHKRD;
      fscs_pkg::ST_PCHKRD:
      begin
        if (memRdata[rowIn[4:0]])
        begin
          resD = fscs_pkg::FAIL_ROW_PROT;
          stateD = fscs_pkg::ST_FINISH;
        end
        else
        begin
          rowBaseD = rowBase;
          cntD = rowBase;
          lastD = rowBase + AW'(ROW_WORDS - 1);
          latchMacroD = rowMacro[7:0];
          stateD = fscs_pkg::ST_WALK;
          opD = fscs_pkg::OP_PROG;
          if (opcodeQ != fscs_pkg::OPC_PROGRAM_ROW)
          begin
            nbRunD = 1'b1;
            post = 1'b1;
            postVal = fscs_pkg::STAT_OK;
          end
          if (opcodeQ == fscs_pkg::OPC_NB_WRITE_ROW)
          begin
            opD = fscs_pkg::OP_PREPROG;
            nbLeftD = fscs_pkg::NB_WRITE_PHASES;
          end
          else if (opcodeQ == fscs_pkg::OPC_NB_PROGRAM_ROW)
          begin
            nbLeftD = fscs_pkg::NB_PROGRAM_PHASES;
          end
        end
      end
      fscs_pkg::ST_WALK:
      begin
        // A request during a background phase is answered without touching flash
        if (nbRunQ && reqQ)
        begin
          post = 1'b1;
          postVal = (opcodeQ == fscs_pkg::OPC_RESUME) ? fscs_pkg::FAIL_IN_PROGRESS
            : fscs_pkg::FAIL_PENDING;
        end
        if (walkEnd)
        begin
          resD = fscs_pkg::STAT_OK;
          if (opQ == fscs_pkg::OP_CSUM)
          begin
            stateD = fscs_pkg::ST_DRAIN;
          end
          else if (nbRunQ)
          begin
            irqD = 1'b1;
            nbRunD = 1'b0;
            clrD = opQ == fscs_pkg::OP_PROG;
            stateD = fscs_pkg::ST_IDLE;
          end
          else if (opQ == fscs_pkg::OP_ERASEALL && thenProtQ)
          begin
            thenProtD = 1'b0;
            opD = fscs_pkg::OP_PROT;
            cntD = supBase0;
            lastD = supBase0 + AW'(PROT_WORDS - 1);
          end
          else if (opQ == fscs_pkg::OP_ERASEALL)
          begin
            stateD = fscs_pkg::ST_CHIPWR;
          end
          else
          begin
            clrD = 1'b1;
            stateD = (opQ == fscs_pkg::OP_PROT && protMacroQ == 8'h00) ? fscs_pkg::ST_CHIPWR
              : fscs_pkg::ST_FINISH;
          end
        end
      end
      fscs_pkg::ST_DRAIN:
      begin
        resD = {fscs_pkg::STAT_OK[31:24], sumD};
        stateD = fscs_pkg::ST_FINISH;
      end
      fscs_pkg::ST_CHIPWR:
      begin
        chipD = newChipQ;
        resD = fscs_pkg::STAT_OK;
        stateD = fscs_pkg::ST_FINISH;
      end
      fscs_pkg::ST_FINISH:
      begin
        post = 1'b1;
        stateD = fscs_pkg::ST_IDLE;
      end
      default:
        stateD = fscs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stateQ <= fscs_pkg::ST_BOOT;
      opQ <= fscs_pkg::OP_CSUM;
      cntQ <= '0;
      lastQ <= '0;
      rowBaseQ <= '0;
      paramQ <= fscs_pkg::ARG_RESET;
      resQ <= fscs_pkg::ARG_RESET;
      nbLeftQ <= 2'h0;
      nbRunQ <= 1'b0;
      thenProtQ <= 1'b0;
      chipQ <= fscs_pkg::PROT_OPEN;
      newChipQ <= fscs_pkg::PROT_OPEN;
      protMacroQ <= 8'h00;
      latchMacroQ <= 8'h00;
    end
    else
    begin
      stateQ <= stateD;
      opQ <= opD;
      cntQ <= cntD;
      lastQ <= lastD;
      rowBaseQ <= rowBaseD;
      paramQ <= paramD;
      resQ <= resD;
      nbLeftQ <= nbLeftD;
      nbRunQ <= nbRunD;
      thenProtQ <= thenProtD;
      chipQ <= chipD;
      newChipQ <= newChipD;
      protMacroQ <= protMacroD;
      latchMacroQ <= latchMacroD;
    end
  end

  // Pulses, checksum and APB answer
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      irqQ <= 1'b0;
      clrQ <= 1'b0;
      sramRdQ <= 1'b0;
      sramAddrQ <= fscs_pkg::ARG_RESET;
      rdPendQ <= 1'b0;
      sumQ <= 24'h00_0000;
      preadyQ <= 1'b0;
      prdataQ <= fscs_pkg::ARG_RESET;
      pslverrQ <= 1'b0;
    end
    else
    begin
      irqQ <= irqD;
      clrQ <= clrD;
      sramRdQ <= sramRdD;
      sramAddrQ <= sramRdD ? argQ : sramAddrQ;
      rdPendQ <= stateQ == fscs_pkg::ST_WALK && opQ == fscs_pkg::OP_CSUM;
      sumQ <= (stateQ == fscs_pkg::ST_DECODE) ? 24'h00_0000 : sumD;
      // One wait state so every APB output comes from a flop
      preadyQ <= apbAccess;
      prdataQ <= apbAccess ? rdMux : prdataQ;
      pslverrQ <= apbAccess ? ~mapped : pslverrQ;
    end
  end

  // Software registers; the sequencer's status write outranks software
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      reqQ <= 1'b0;
      opcodeQ <= fscs_pkg::OPCODE_RESET;
      argQ <= fscs_pkg::ARG_RESET;
      ctrlQ <= fscs_pkg::CTRL_RESET;
    end
    else
    begin
      reqQ <= post ? 1'b0 : swReqWr ? pwdata[fscs_pkg::REQ_BIT] : reqQ;
      opcodeQ <= swReqWr ? pwdata[15:0] : opcodeQ;
      argQ <= post ? postVal : swArgWr ? pwdata : argQ;
      ctrlQ <= (apbWrite & selCtrl) ? pwdata[1:0] : ctrlQ;
    end
  end

  assign prdata = prdataQ;
  assign pready = preadyQ;
  assign pslverr = pslverrQ;
  assign sramRdEn = sramRdQ;
  assign sramAddr = sramAddrQ;
  assign latchMacro = latchMacroQ;
  assign latchIdx = cntQ[WB-1:0];
  assign latchClear = clrQ;
  assign progIrq = irqQ;

endmodule : fscs_sequencer

`default_nettype wire

// File: shared/fscs_pkg.sv
`default_nettype none

package fscs_pkg;

  // Register offsets (byte addresses on the APB)
  localparam logic [11:0] REQ_OFFSET = 12'h004;
  localparam logic [11:0] ARG_OFFSET = 12'h008;
  localparam logic [11:0] CTRL_OFFSET = 12'h00C;
  localparam logic [11:0] STAT_OFFSET = 12'h010;

  // Field positions
  localparam int REQ_BIT = 31;
  localparam int CTRL_DEBUG_PORT_BIT = 0;
  localparam int CTRL_PROG_MODE_BIT = 1;

  // Values after reset
  localparam logic [31:0] ARG_RESET = 32'h0000_0000;
  localparam logic [15:0] OPCODE_RESET = 16'h0000;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Call keys
  localparam logic [7:0] FIRST_CALL_KEY = 8'hB6;
  localparam logic [7:0] KEY_PROGRAM_ROW = 8'hD9;
  localparam logic [7:0] KEY_NB_WRITE_ROW = 8'hDA;
  localparam logic [7:0] KEY_NB_PROGRAM_ROW = 8'hDB;
  localparam logic [7:0] KEY_RESUME = 8'hDC;
  localparam logic [7:0] KEY_ERASE_ALL = 8'hDD;
  localparam logic [7:0] KEY_CHECKSUM = 8'hDE;
  localparam logic [7:0] KEY_WRITE_PROT = 8'hE0;

  // Opcodes
  localparam logic [15:0] OPC_PROGRAM_ROW = 16'h0006;
  localparam logic [15:0] OPC_NB_WRITE_ROW = 16'h0007;
  localparam logic [15:0] OPC_NB_PROGRAM_ROW = 16'h0008;
  localparam logic [15:0] OPC_RESUME = 16'h0009;
  localparam logic [15:0] OPC_ERASE_ALL = 16'h000A;
  localparam logic [15:0] OPC_CHECKSUM = 16'h000B;
  localparam logic [15:0] OPC_WRITE_PROT = 16'h000D;

  localparam logic [15:0] CHECKSUM_ALL_ROWS = 16'h8000;

  // Chip protection codes
  localparam logic [7:0] PROT_OPEN = 8'h01;
  localparam logic [7:0] PROT_PROTECTED = 8'h02;
  localparam logic [7:0] PROT_KILL = 8'h04;

  // Status words
  localparam logic [31:0] STAT_OK = 32'hA000_0000;
  localparam logic [31:0] FAIL_PROT_MODE = 32'hF000_0001;
  localparam logic [31:0] FAIL_ADDRESS = 32'hF000_0004;
  localparam logic [31:0] FAIL_ROW_PROT = 32'hF000_0005;
  localparam logic [31:0] FAIL_RESUMED = 32'hF000_0007;
  localparam logic [31:0] FAIL_PENDING = 32'hF000_0008;
  localparam logic [31:0] FAIL_IN_PROGRESS = 32'hF000_0009;
  localparam logic [31:0] FAIL_OPCODE = 32'hF000_000B;
  localparam logic [31:0] FAIL_KEY = 32'hF000_000C;

  // Resumes owed after each non-blocking call
  localparam logic [1:0] NB_WRITE_PHASES = 2'h3;
  localparam logic [1:0] NB_PROGRAM_PHASES = 2'h1;

  typedef enum logic [3:0] {
    ST_BOOT = 4'b0000,
    ST_BOOTRD = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_FETCH = 4'b0011,
    ST_DECODE = 4'b0100,
    ST_PCHK = 4'b0101,
    ST_PCHKRD = 4'b0110,
    ST_WALK = 4'b0111,
    ST_DRAIN = 4'b1000,
    ST_CHIPWR = 4'b1001,
    ST_FINISH = 4'b1010
  } fscs_state_t;

  typedef enum logic [2:0] {
    OP_PREPROG = 3'b000,
    OP_ERASE = 3'b001,
    OP_PROG = 3'b010,
    OP_PROT = 3'b011,
    OP_ERASEALL = 3'b100,
    OP_CSUM = 3'b101
  } fscs_op_t;

  // Returns {known, expected second key} for an opcode
  function automatic logic [8:0] keyFor(input logic [15:0] opc);
    case (opc)
      OPC_PROGRAM_ROW: keyFor = {1'b1, KEY_PROGRAM_ROW};
      OPC_NB_WRITE_ROW: keyFor = {1'b1, KEY_NB_WRITE_ROW};
      OPC_NB_PROGRAM_ROW: keyFor = {1'b1, KEY_NB_PROGRAM_ROW};
      OPC_RESUME: keyFor = {1'b1, KEY_RESUME};
      OPC_ERASE_ALL: keyFor = {1'b1, KEY_ERASE_ALL};
      OPC_CHECKSUM: keyFor = {1'b1, KEY_CHECKSUM};
      OPC_WRITE_PROT: keyFor = {1'b1, KEY_WRITE_PROT};
      default: keyFor = 9'h000;
    endcase
  endfunction : keyFor

endpackage : fscs_pkg

`default_nettype wire

// File: src/fscs_flash_mem.sv
`default_nettype none

module fscs_flash_mem #(
  parameter int DW = 32,
  parameter int DEPTH = 4160,
  parameter int AW = 13
) (
  // Clock
  input wire logic ref_clk,
  // Single port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  // No reset: contents are non-volatile, so the array starts unknown in simulation
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : fscs_flash_mem

`default_nettype wire

// File: tb/fscs_sram_model.sv
`default_nettype none

module fscs_sram_model (
  // Clock
  input wire logic ref_clk,
  // Parameter fetch
  input wire logic sramRdEn,
  output logic [31:0] sramRdata,
  output logic sramRvalid,
  // Page latch
  input wire logic latchClear,
  output logic [31:0] latchRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] word = 32'h0000_0000;
  logic [31:0] latchWord = 32'h0000_0000;
  logic slow = 1'b0;
  int pend = 0;
  initial sramRvalid = 1'b0;
  initial sramRdata = 32'h0000_0000;
  // Latch words all alike, so the row sum is easy to predict
  assign latchRdata = latchWord;
  always @(posedge ref_clk)
  begin
    sramRvalid <= 1'b0;
    // An idle bus inverts every bit each cycle, so the last word shows every other cycle
    sramRdata <= ~sramRdata;
    if (sramRdEn)
      pend <= slow ? 3 : 1;
    else if (pend > 1)
      pend <= pend - 1;
    else if (pend == 1)
    begin
      sramRvalid <= 1'b1;
      sramRdata <= word;
      pend <= 0;
    end
    if (latchClear)
      latchWord <= 32'h0000_0000;
  end
endmodule : fscs_sram_model

`default_nettype wire

// File: tb/fscs_monitor.sv
`default_nettype none

module fscs_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Flash side
  input wire logic sramRdEn,
  input wire logic latchClear,
  input wire logic progIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_ready_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not one wait state");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than a cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_unmapped: assert property (pready && paddr == 12'h020 |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && paddr == 12'h008 |-> !pslverr)
    else $error("error on mapped address");
  a_irq_single: assert property (progIrq |=> !progIrq)
    else $error("interrupt pulse too long");
  a_clear_single: assert property (latchClear |=> !latchClear)
    else $error("latch clear pulse too long");
  a_fetch_single: assert property (sramRdEn |=> !sramRdEn)
    else $error("fetch pulse too long");
  c_irq: cover property (progIrq);
  c_err: cover property (pslverr);
  c_clear: cover property (latchClear);
endmodule : fscs_monitor

bind fscs_sequencer fscs_monitor u_mon (.ref_clk(ref_clk), .srst(srst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .sramRdEn(sramRdEn), .latchClear(latchClear), .progIrq(progIrq));

`default_nettype wire

// File: tb/flash_system_call_sequencer_test.sv
`default_nettype none

module flash_system_call_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, sramRdata, latchRdata, rd, sramAddr;
  logic pready, pslverr, sramRdEn, sramRvalid, latchClear, progIrq, err;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int irqs = 0;
  fscs_sequencer #(.ROW_BYTES(16)) dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sramRdEn(sramRdEn), .sramAddr(sramAddr),
    .sramRdata(sramRdata), .sramRvalid(sramRvalid), .latchMacro(), .latchIdx(),
    .latchRdata(latchRdata), .latchClear(latchClear), .progIrq(progIrq));
  fscs_sram_model sram (.ref_clk(ref_clk), .sramRdEn(sramRdEn), .sramRdata(sramRdata),
    .sramRvalid(sramRvalid), .latchClear(latchClear), .latchRdata(latchRdata));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic complete_run;
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic call(input logic [31:0] arg, input logic [15:0] op, input logic [31:0] exp);
    apb(1'b1, fscs_pkg::ARG_OFFSET, arg);
    apb(1'b1, fscs_pkg::REQ_OFFSET, {16'h8000, op});
    do apb(1'b0, fscs_pkg::REQ_OFFSET, 32'h0000_0000); while (rd[31] !== 1'b0);
    apb(1'b0, fscs_pkg::ARG_OFFSET, 32'h0000_0000);
    check(rd, exp);
  endtask : call
  always @(posedge ref_clk)
  begin
    cyc++;
    if (progIrq === 1'b1)
      irqs++;
    if (cyc == 30000)
    begin
      fails++;
      complete_run();
    end
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    apb(1'b0, fscs_pkg::ARG_OFFSET, 32'h0000_0000);
    check(rd, fscs_pkg::ARG_RESET);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    sram.word = 32'hFFFF_DDB6;
    call(32'h0000_0000, fscs_pkg::OPC_ERASE_ALL, fscs_pkg::FAIL_PROT_MODE);
    apb(1'b1, fscs_pkg::CTRL_OFFSET, 32'h0000_0003);
    call(32'h0000_0000, fscs_pkg::OPC_ERASE_ALL, fscs_pkg::STAT_OK);
    call(32'h0001_E0B6, fscs_pkg::OPC_WRITE_PROT, fscs_pkg::STAT_OK);
    sram.word = 32'h0001_D9B6;
    sram.slow = 1'b1;
    call(32'h0000_0000, fscs_pkg::OPC_NB_WRITE_ROW, fscs_pkg::FAIL_KEY);
    sram.slow = 1'b0;
    call(32'h2000_0040, 16'h0003, fscs_pkg::FAIL_OPCODE);
    check(sramAddr, 32'h2000_0040);
    sram.latchWord = 32'h0102_0304;
    call(32'h0000_0000, fscs_pkg::OPC_PROGRAM_ROW, fscs_pkg::STAT_OK);
    call(32'h0001_DEB6, fscs_pkg::OPC_CHECKSUM, 32'hA000_0028);
    call(32'h8000_DEB6, fscs_pkg::OPC_CHECKSUM, 32'hA000_0029);
    sram.latchWord = 32'h0102_0304;
    sram.word = 32'h0002_DBB6;
    irqs = 0;
    call(32'h0000_0000, fscs_pkg::OPC_NB_PROGRAM_ROW, fscs_pkg::STAT_OK);
    call(32'h0002_DEB6, fscs_pkg::OPC_CHECKSUM, fscs_pkg::FAIL_PENDING);
    while (irqs < 1) @(posedge ref_clk);
    sram.word = 32'hFFFF_DCB6;
    call(32'h0000_0000, fscs_pkg::OPC_RESUME, fscs_pkg::STAT_OK);
    call(32'h0000_0000, fscs_pkg::OPC_RESUME, fscs_pkg::FAIL_RESUMED);
    check(32'(irqs), 32'h0000_0001);
    sram.latchWord = 32'h0102_0304;
    sram.word = 32'h0003_DAB6;
    irqs = 0;
    call(32'h0000_0000, fscs_pkg::OPC_NB_WRITE_ROW, fscs_pkg::STAT_OK);
    sram.word = 32'hFFFF_DCB6;
    for (int i = 1; i <= 3; i++)
    begin
      while (irqs < i) @(posedge ref_clk);
      call(32'h0000_0000, fscs_pkg::OPC_RESUME, fscs_pkg::STAT_OK);
    end
    check(32'(irqs), 32'h0000_0003);
    call(32'h0003_DEB6, fscs_pkg::OPC_CHECKSUM, 32'hA000_0028);
    sram.latchWord = 32'h0000_0010;
    call(32'h0001_E0B6, fscs_pkg::OPC_WRITE_PROT, fscs_pkg::STAT_OK);
    sram.word = 32'h0004_D9B6;
    call(32'h0000_0000, fscs_pkg::OPC_PROGRAM_ROW, fscs_pkg::FAIL_ROW_PROT);
    call(32'h0002_E0B6, fscs_pkg::OPC_WRITE_PROT, fscs_pkg::STAT_OK);
    sram.word = 32'hFFFF_DDB6;
    call(32'h0000_0000, fscs_pkg::OPC_ERASE_ALL, fscs_pkg::FAIL_PROT_MODE);
    call(32'h0001_E0B6, fscs_pkg::OPC_WRITE_PROT, fscs_pkg::STAT_OK);
    call(32'h8000_DEB6, fscs_pkg::OPC_CHECKSUM, 32'hA000_0001);
    complete_run();
  end
endmodule : flash_system_call_sequencer_test

`default_nettype wire
